// >>> hw/dsc_pkg.sv
package dsc_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [15:0] ADDR_ASYNC_MODE = 16'hff70;
    localparam logic [15:0] ADDR_SYNC_MODE  = 16'hff72;
    localparam logic [15:0] ADDR_DATA       = 16'hff74;  // Shared transmit / receive data address
    localparam logic [15:0] ADDR_ERR_STAT   = 16'hff76;

    localparam logic [7:0] ASYNC_MODE_RST = 8'h00;
    localparam logic [7:0] SYNC_MODE_RST  = 8'h00;
    localparam logic [7:0] TX_SHIFT_RST   = 8'hff;
    localparam logic [7:0] RX_HOLD_RST    = 8'hff;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int AM_TX_EN   = 7;
    localparam int AM_RX_EN   = 6;
    localparam int AM_PAR_HI  = 5;
    localparam int AM_PAR_LO  = 4;
    localparam int AM_CHAR8   = 3;
    localparam int AM_STOP2   = 2;
    localparam int AM_ERR_MSK = 1;
    localparam int AM_CLK_SEL = 0;
    localparam int SM_ENABLE  = 7;
    localparam int SM_LSB_1ST = 2;
    localparam int SM_CLK_SEL = 1;
    localparam logic [7:0] SM_WR_MASK = 8'h86;   // Bits 0, 3..6 held at zero

    localparam int ES_PARITY  = 2;
    localparam int ES_FRAMING = 1;
    localparam int ES_OVERRUN = 0;

    // Parity modes
    typedef enum logic [1:0] {
        PAR_NONE = 2'b00,
        PAR_ZERO = 2'b01,
        PAR_ODD  = 2'b10,
        PAR_EVEN = 2'b11
    } dsc_par_t;

    // Oversampling of one asynchronous bit, in ticks
    localparam logic [3:0] OVS_LAST = 4'hf;
    localparam logic [3:0] OVS_MID  = 4'h7;
    localparam logic [3:0] BITS_7   = 4'h7;
    localparam logic [3:0] BITS_8   = 4'h8;

endpackage : dsc_pkg

// >>> hw/dsc_sync3.sv
`timescale 1ns/1ps
// Three-stage pin synchroniser; a change counts once stages two and three agree
module dsc_sync3 (
    input  wire logic clock,
    input  wire logic rst,
    input  wire logic pin,
    output logic      level,
    output logic      rise,
    output logic      fall
);
    logic [2:0] s_q;
    logic [2:0] s_d;
    logic       lvl_q;
    logic       lvl_d;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        s_d   = {s_q[1:0], pin};
        lvl_d = (s_q[2] == s_q[1]) ? s_q[1] : lvl_q;
    end

    // Reset to idle-high so a quiet line raises no edge
    always_ff @(posedge clock) begin
        if (rst) begin
            s_q   <= 3'h7;
            lvl_q <= 1'b1;
        end else begin
            s_q   <= s_d;
            lvl_q <= lvl_d;
        end
    end

    assign level = lvl_q;
    assign rise  = lvl_d & ~lvl_q;
    assign fall  = ~lvl_d & lvl_q;
endmodule : dsc_sync3

// >>> hw/dsc_channel.sv
`timescale 1ns/1ps
// Behaviour
// - Seven-bit length sends data bits 0..6 only; eight-bit sends all.
// - Writing transmit data starts the transmission at once.
// - Transmit shifter is write-only, byte wide, all ones after reset.
// - Transmit and receive data share one address: read receive, write transmit.
// - Each complete received character moves from shifter to holding register.
// - Seven-bit receive fills bits 0..6 and clears bit 7.
// - Receive holding is read-only, byte wide, all ones after reset.
// - Transmitter adds start, optional parity and stop bits per mode register.
// - Receiver checks parity and framing errors, records them in status.
// - Sync mode register resets zero; bit 7 enables, bit 2 picks LSB first.
// - Sync clock select: zero external shift clock pin, one baud generator.
// - Async mode register resets zero; bit 7 transmit, bit 6 receive enable.
// - Parity field: none, send zero without check, odd, even.
// - Stop length bit: zero one stop bit, one two stop bits.
// - Error mask set withholds receive-complete interrupt on errored characters.
// - Async clock select: zero external clock pin, one baud generator.
module dsc_channel
    import dsc_pkg::*;
#(
    parameter int BAUD_DIV = 16   // Baud generator divide, clock cycles per tick
) (
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic [15:0] addr,
    input  wire logic        wr_en,
    input  wire logic        rd_en,
    input  wire logic [7:0]  wr_data,
    output logic      [7:0]  rd_data,
    input  wire logic        rx_line,
    output logic             tx_line,
    input  wire logic        async_ext_clock_pin,
    input  wire logic        sync_shift_clock_pin,
    output logic             sync_clock_out,
    output logic             sync_clock_oe_n,
    output logic             async_pin_is_port,
    output logic             rx_done_irq,
    output logic             tx_done_irq,
    output logic             tx_busy
);
    import dsc_pkg::*;

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic rx_lvl;
    logic rx_rise;
    logic rx_fall;
    logic ack_lvl;
    logic ack_rise;
    logic ack_fall;
    logic sck_lvl;
    logic sck_rise;
    logic sck_fall;

    dsc_sync3 u_rx  (.clock(clock), .rst(rst), .pin(rx_line),
                     .level(rx_lvl), .rise(rx_rise), .fall(rx_fall));
    dsc_sync3 u_ack (.clock(clock), .rst(rst), .pin(async_ext_clock_pin),
                     .level(ack_lvl), .rise(ack_rise), .fall(ack_fall));
    dsc_sync3 u_sck (.clock(clock), .rst(rst), .pin(sync_shift_clock_pin),
                     .level(sck_lvl), .rise(sck_rise), .fall(sck_fall));

    // ------------------------------------------------------------
    // Registers and baud divider
    // ------------------------------------------------------------
    logic [7:0]  am_q, am_d, sm_q, sm_d, tx_q, tx_d, rh_q, rh_d, es_q, es_d;
    logic [15:0] bd_q, bd_d;
    logic        brg_tick;
    logic        wr_data_hit;
    logic        rd_data_hit;

    assign wr_data_hit = wr_en && (addr == ADDR_DATA);
    assign rd_data_hit = rd_en && (addr == ADDR_DATA);
    assign brg_tick    = (bd_q == 16'(BAUD_DIV - 1));

    logic       sync_mode;
    logic       tick;
    logic       rx_fin, rx_perr, rx_ferr;
    logic [7:0] rx_word;

    assign sync_mode = sm_q[SM_ENABLE];
    // Async tick from the generator or the external clock pin edges
    assign tick = am_q[AM_CLK_SEL] ? brg_tick : ack_rise;

    // Register writes; the clear of status on read loses to a new error
    always_comb begin
        am_d = am_q;
        sm_d = sm_q;
        tx_d = tx_q;
        rh_d = rh_q;
        es_d = es_q;
        bd_d = brg_tick ? 16'h0000 : bd_q + 16'h0001;
        if (wr_en && addr == ADDR_ASYNC_MODE) begin
            am_d = wr_data;
        end else if (wr_en && addr == ADDR_SYNC_MODE) begin
            sm_d = wr_data & SM_WR_MASK;
        end else if (wr_data_hit) begin
            tx_d = wr_data;
        end
        if (rd_en && addr == ADDR_ERR_STAT) begin
            es_d = 8'h00;
        end
        if (rx_fin) begin
            rh_d = rx_word;
            es_d[ES_PARITY]  = es_d[ES_PARITY] | rx_perr;
            es_d[ES_FRAMING] = es_d[ES_FRAMING] | rx_ferr;
        end
    end

    // Registers reset to documented values
    always_ff @(posedge clock) begin
        if (rst) begin
            am_q <= ASYNC_MODE_RST;
            sm_q <= SYNC_MODE_RST;
            tx_q <= TX_SHIFT_RST;
            rh_q <= RX_HOLD_RST;
            es_q <= 8'h00;
            bd_q <= 16'h0000;
        end else begin
            am_q <= am_d;
            sm_q <= sm_d;
            tx_q <= tx_d;
            rh_q <= rh_d;
            es_q <= es_d;
            bd_q <= bd_d;
        end
    end

    // Read mux; transmit shifter is never readable
    always_comb begin
        if (addr == ADDR_ASYNC_MODE) begin
            rd_data = am_q;
        end else if (addr == ADDR_SYNC_MODE) begin
            rd_data = sm_q;
        end else if (addr == ADDR_DATA) begin
            rd_data = rh_q;
        end else if (addr == ADDR_ERR_STAT) begin
            rd_data = es_q;
        end else begin
            rd_data = 8'h00;
        end
    end

    assign async_pin_is_port = am_q[AM_CLK_SEL];

    // ------------------------------------------------------------
    // Transmitter
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        TX_IDLE  = 3'b000,
        TX_START = 3'b001,
        TX_DATA  = 3'b010,
        TX_PAR   = 3'b011,
        TX_STOP  = 3'b100,
        TX_SYNC  = 3'b101
    } dsc_txst_t;

    dsc_txst_t  ts_q, ts_d;
    logic [7:0] ts_sh_q, ts_sh_d;
    logic [3:0] ts_bit_q, ts_bit_d, ts_ov_q, ts_ov_d;
    logic       ts_par_q, ts_par_d, tx_line_q, tx_line_d, ts_stop_q, ts_stop_d, txi_d, txi_q;
    logic [3:0] nbits;
    logic       sync_edge_out, sync_edge_in, sc_q, sc_d;
    dsc_par_t   pmode;

    assign nbits = am_q[AM_CHAR8] ? BITS_8 : BITS_7;
    assign pmode = dsc_par_t'(am_q[AM_PAR_HI:AM_PAR_LO]);
    // Sync shift clock: internal divider toggles, or external edges
    // Data moves on the falling shift clock and is sampled on the rising one, in both clock modes
    assign sync_edge_out = sm_q[SM_CLK_SEL] ? (brg_tick & sc_q)  : sck_fall;
    assign sync_edge_in  = sm_q[SM_CLK_SEL] ? (brg_tick & ~sc_q) : sck_rise;

    // Transmit next state; a data write launches straight away
    always_comb begin
        ts_d = ts_q; ts_sh_d = ts_sh_q; ts_bit_d = ts_bit_q; ts_ov_d = ts_ov_q;
        ts_par_d = ts_par_q; tx_line_d = tx_line_q; ts_stop_d = ts_stop_q;
        txi_d = 1'b0;
        sc_d = sc_q;
        case (ts_q)
            TX_IDLE: begin
                tx_line_d = 1'b1;
                sc_d = 1'b1;
                if (wr_data_hit && sync_mode) begin
                    ts_d = TX_SYNC; ts_sh_d = wr_data; ts_bit_d = 4'h0;
                    tx_line_d = sm_q[SM_LSB_1ST] ? wr_data[0] : wr_data[7];
                end else if (wr_data_hit && am_q[AM_TX_EN]) begin
                    ts_d = TX_START; ts_sh_d = wr_data; ts_ov_d = 4'h0;
                    ts_par_d = (pmode == PAR_ODD);
                    tx_line_d = 1'b0;
                end
            end
            TX_SYNC: begin
                if (sm_q[SM_CLK_SEL] && brg_tick) begin
                    sc_d = ~sc_q;
                end
                if (sync_edge_in) begin
                    ts_bit_d = ts_bit_q + 4'h1;
                    if (ts_bit_q == BITS_7) begin
                        ts_d = TX_IDLE; txi_d = 1'b1; sc_d = 1'b1;
                    end
                end else if (sync_edge_out && ts_bit_q != 4'h0) begin
                    tx_line_d = sm_q[SM_LSB_1ST] ? ts_sh_q[ts_bit_q[2:0]]
                                                 : ts_sh_q[3'(BITS_7) - ts_bit_q[2:0]];
                end
            end
            default: begin
                if (~am_q[AM_TX_EN]) begin
                    ts_d = TX_IDLE; tx_line_d = 1'b1;
                end else if (tick) begin
                    ts_ov_d = ts_ov_q + 4'h1;
                    if (ts_ov_q == OVS_LAST) begin
                        case (ts_q)
                            TX_START: begin
                                ts_d = TX_DATA; ts_bit_d = 4'h0; tx_line_d = ts_sh_q[0];
                            end
                            TX_DATA: begin
                                ts_par_d = ts_par_q ^ ts_sh_q[ts_bit_q[2:0]];
                                ts_bit_d = ts_bit_q + 4'h1;
                                if (ts_bit_q + 4'h1 < nbits) begin
                                    tx_line_d = ts_sh_q[3'(ts_bit_q + 4'h1)];
                                end else if (pmode != PAR_NONE) begin
                                    ts_d = TX_PAR;
                                    tx_line_d = (pmode == PAR_ZERO) ? 1'b0
                                              : ts_par_q ^ ts_sh_q[ts_bit_q[2:0]];
                                end else begin
                                    ts_d = TX_STOP; ts_stop_d = am_q[AM_STOP2]; tx_line_d = 1'b1;
                                end
                            end
                            TX_PAR: begin
                                ts_d = TX_STOP; ts_stop_d = am_q[AM_STOP2]; tx_line_d = 1'b1;
                            end
                            default: begin
                                if (ts_stop_q) begin
                                    ts_stop_d = 1'b0;
                                end else begin
                                    ts_d = TX_IDLE; txi_d = 1'b1;
                                end
                            end
                        endcase
                    end
                end
            end
        endcase
    end

    // Transmit registers
    always_ff @(posedge clock) begin
        if (rst) begin
            ts_q <= TX_IDLE; ts_sh_q <= 8'h00; ts_bit_q <= 4'h0; ts_ov_q <= 4'h0;
            ts_par_q <= 1'b0; tx_line_q <= 1'b1; ts_stop_q <= 1'b0; txi_q <= 1'b0; sc_q <= 1'b1;
        end else begin
            ts_q <= ts_d; ts_sh_q <= ts_sh_d; ts_bit_q <= ts_bit_d; ts_ov_q <= ts_ov_d;
            ts_par_q <= ts_par_d; tx_line_q <= tx_line_d; ts_stop_q <= ts_stop_d;
            txi_q <= txi_d; sc_q <= sc_d;
        end
    end

    assign tx_line         = tx_line_q;
    assign tx_busy         = (ts_q != TX_IDLE);    // Software polls this before writing
    assign tx_done_irq     = txi_q;
    assign sync_clock_out  = sc_q;
    assign sync_clock_oe_n = ~(sync_mode & sm_q[SM_CLK_SEL]);   // Low while driving

    // ------------------------------------------------------------
    // Receiver
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        RX_IDLE = 2'b00,
        RX_BITS = 2'b01,
        RX_SYNC = 2'b10
    } dsc_rxst_t;

    dsc_rxst_t  rs_q, rs_d;
    logic [9:0] rs_sh_q, rs_sh_d;   // Data, parity and stop, in arrival order
    logic [3:0] rs_cnt_q, rs_cnt_d, rs_ov_q, rs_ov_d, rs_len;
    logic       rxi_q, rxi_d, rs_par;
    logic [7:0] rs_dat;

    assign rs_len = nbits + ((pmode != PAR_NONE) ? 4'h2 : 4'h1);
    assign rs_dat = rs_sh_q[10 - int'(rs_len) +: 8];   // First data bit sits ten minus length up
    // Parity and stop bit checks on the assembled frame
    always_comb begin
        rx_word = am_q[AM_CHAR8] ? rs_dat : {1'b0, rs_dat[6:0]};
        rs_par  = ^rx_word ^ rs_sh_q[8];
        rx_perr = 1'b0;
        rx_ferr = 1'b0;
        if (rs_q == RX_SYNC) begin
            rx_word = sm_q[SM_LSB_1ST] ? rs_sh_q[9:2]
                                       : {rs_sh_q[2], rs_sh_q[3], rs_sh_q[4], rs_sh_q[5],
                                          rs_sh_q[6], rs_sh_q[7], rs_sh_q[8], rs_sh_q[9]};
        end else begin
            rx_ferr = ~rs_sh_q[9];
            if (pmode == PAR_ODD) begin
                rx_perr = ~rs_par;
            end else if (pmode == PAR_EVEN) begin
                rx_perr = rs_par;
            end
        end
    end

    // Receive next state
    always_comb begin
        rs_d = rs_q; rs_sh_d = rs_sh_q; rs_cnt_d = rs_cnt_q; rs_ov_d = rs_ov_q;
        rx_fin = 1'b0;
        rxi_d = 1'b0;
        case (rs_q)
            RX_IDLE: begin
                rs_cnt_d = 4'h0;
                rs_ov_d  = 4'h0;
                if (sync_mode && ts_q == TX_SYNC) begin
                    rs_d = RX_SYNC;
                end else if (am_q[AM_RX_EN] && ~rx_lvl) begin
                    rs_d = RX_BITS;
                end
            end
            RX_SYNC: begin
                if (sync_edge_in) begin
                    rs_sh_d = {rx_lvl, rs_sh_q[9:1]};
                    rs_cnt_d = rs_cnt_q + 4'h1;
                end
                // Eighth bit lands as the transmitter idles; hand the byte over one cycle later
                if (ts_q == TX_IDLE) begin
                    rs_d = RX_IDLE; rx_fin = 1'b1; rxi_d = 1'b1;
                end
            end
            default: begin
                if (~am_q[AM_RX_EN]) begin
                    rs_d = RX_IDLE;
                end else if (tick) begin
                    rs_ov_d = rs_ov_q + 4'h1;
                    if (rs_ov_q == OVS_MID) begin
                        if (rs_cnt_q == 4'h0 && rx_lvl) begin
                            rs_d = RX_IDLE;                          // False start
                        end else if (rs_cnt_q != 4'h0) begin
                            rs_sh_d = {rx_lvl, rs_sh_q[9:1]};
                        end
                        rs_cnt_d = rs_cnt_q + 4'h1;
                    end
                    if (rs_ov_q == OVS_LAST && rs_cnt_q == rs_len + 4'h1) begin
                        rs_d = RX_IDLE;
                        rx_fin = 1'b1;
                        rxi_d = ~(am_q[AM_ERR_MSK] & (rx_perr | rx_ferr));
                    end
                end
            end
        endcase
    end

    // Receive registers
    always_ff @(posedge clock) begin
        if (rst) begin
            rs_q <= RX_IDLE; rs_sh_q <= 10'h000; rs_cnt_q <= 4'h0; rs_ov_q <= 4'h0; rxi_q <= 1'b0;
        end else begin
            rs_q <= rs_d; rs_sh_q <= rs_sh_d; rs_cnt_q <= rs_cnt_d; rs_ov_q <= rs_ov_d; rxi_q <= rxi_d;
        end
    end

    assign rx_done_irq = rxi_q;
endmodule : dsc_channel

// >>> verif/dsc_channel_asserts.sv
`timescale 1ns/1ps
module dsc_channel_chk
    import dsc_pkg::*;
#(
    parameter int BAUD_DIV = 16
) (
    input wire logic        clock,
    input wire logic        rst,
    input wire logic [15:0] addr,
    input wire logic        wr_en,
    input wire logic [7:0]  wr_data,
    input wire logic [7:0]  rd_data,
    input wire logic        tx_line,
    input wire logic        sync_clock_oe_n,
    input wire logic        async_pin_is_port,
    input wire logic        rx_done_irq,
    input wire logic        tx_done_irq,
    input wire logic        tx_busy
);
    logic [7:0] am_q, am_d, sm_q, sm_d;
    // ----------------------------------------
    // Mode register shadows
    // ----------------------------------------
    // Built from bus writes alone, never from design internals
    always_comb begin
        am_d = am_q;
        sm_d = sm_q;
        if (wr_en && addr == ADDR_ASYNC_MODE) am_d = wr_data;
        if (wr_en && addr == ADDR_SYNC_MODE) sm_d = wr_data & SM_WR_MASK;
    end
    always_ff @(posedge clock) begin
        am_q <= rst ? 8'h00 : am_d;
        sm_q <= rst ? 8'h00 : sm_d;
    end
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    reset_idle_a: assert property ($fell(rst) |-> tx_line && !tx_busy)
        else $error("line not idle after reset");
    tx_launch_a: assert property (wr_en && addr == ADDR_DATA && am_q[AM_TX_EN] && !sm_q[SM_ENABLE]
        && !tx_busy |=> tx_busy && !tx_line) else $error("write did not start frame");
    start_low_a: assert property ($fell(tx_line) && !sm_q[SM_ENABLE] |-> !tx_line [*8])
        else $error("start bit too short");
    done_high_a: assert property (tx_done_irq && !sm_q[SM_ENABLE] |-> tx_line)
        else $error("frame ended off stop level");
    idle_high_a: assert property (!tx_busy && !sm_q[SM_ENABLE] && !$past(sm_q[SM_ENABLE])
        && !$past(sm_q[SM_ENABLE], 2) |-> tx_line) else $error("idle line low");
    am_read_a: assert property (addr == ADDR_ASYNC_MODE |-> rd_data == am_q)
        else $error("async mode readback wrong");
    sm_read_a: assert property (addr == ADDR_SYNC_MODE |-> rd_data == sm_q)
        else $error("sync mode readback wrong");
    pin_port_a: assert property (async_pin_is_port == am_q[AM_CLK_SEL])
        else $error("clock pin use wrong");
    sclk_drive_a: assert property (sync_clock_oe_n == !(sm_q[SM_ENABLE] && sm_q[SM_CLK_SEL]))
        else $error("shift clock drive wrong");
    cover property ($rose(tx_busy));
    cover property (rx_done_irq);
    cover property (!sync_clock_oe_n && tx_busy);
endmodule : dsc_channel_chk

bind dsc_channel dsc_channel_chk #(.BAUD_DIV(BAUD_DIV)) chk (.clock(clock), .rst(rst), .addr(addr),
    .wr_en(wr_en), .wr_data(wr_data), .rd_data(rd_data), .tx_line(tx_line), .sync_clock_oe_n(sync_clock_oe_n),
    .async_pin_is_port(async_pin_is_port), .rx_done_irq(rx_done_irq), .tx_done_irq(tx_done_irq),
    .tx_busy(tx_busy));

// >>> verif/dsc_peer.sv
`timescale 1ns/1ps
module dsc_peer #(
    parameter int BIT_CYC = 32
) (
    input  wire logic clock,
    input  wire logic tx_line,
    output logic      rx_line
);
    logic [11:0] frame;
    int          frames = 0;
    // ----------------------------------------
    // Serial peer
    // ----------------------------------------
    // Released line sits high, as a pulled-up receive input would
    initial rx_line = 1'b1;
    // Mid-bit capture of twelve bits after each falling edge; trailing idle reads as ones
    initial forever begin
        @(negedge tx_line);
        repeat (BIT_CYC / 2) @(posedge clock);
        for (int k = 0; k < 12; k++) begin
            frame[k] = tx_line;
            repeat (BIT_CYC) @(posedge clock);
        end
        frames++;
    end
    // Frame out LSB first, start low, stop high
    task automatic send(input logic [11:0] f, input int n);
        for (int k = 0; k < n; k++) begin
            @(posedge clock);
            #1 rx_line = f[k];
            repeat (BIT_CYC - 1) @(posedge clock);
        end
        rx_line = 1'b1;
    endtask : send
endmodule : dsc_peer

// >>> verif/dual_mode_serial_channel_test.sv
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin failures++; $display("Error t=%0t got %h exp %h", $time, (g), (e)); end end
module dual_mode_serial_channel_test;
    import dsc_pkg::*;
    localparam int BD = 2;
    localparam int BC = 16 * BD;  // Clock cycles per async bit
    logic        clock = 0, rst = 1, wr_en = 0, rd_en = 0, ext_clk = 0, sclk_in = 0;
    logic [15:0] addr = '0;
    logic [7:0]  wr_data = '0, rd_data, v;
    logic        rx_line, tx_line, sclk_out, sclk_oe_n, pin_port, rx_irq, tx_irq, tx_busy;
    int          failures = 0, compares = 0, rx_cnt = 0;

    dsc_channel #(.BAUD_DIV(BD)) uut (.clock(clock), .rst(rst), .addr(addr), .wr_en(wr_en), .rd_en(rd_en),
        .wr_data(wr_data), .rd_data(rd_data), .rx_line(rx_line), .tx_line(tx_line),
        .async_ext_clock_pin(ext_clk), .sync_shift_clock_pin(sclk_in), .sync_clock_out(sclk_out),
        .sync_clock_oe_n(sclk_oe_n), .async_pin_is_port(pin_port), .rx_done_irq(rx_irq),
        .tx_done_irq(tx_irq), .tx_busy(tx_busy));
    dsc_peer #(.BIT_CYC(BC)) peer (.clock(clock), .tx_line(tx_line), .rx_line(rx_line));

    // ----------------------------------------
    // Clock, pulse counting, bus tasks
    // ----------------------------------------
    always #12.5 clock = ~clock;
    // Count pulses here so masked ones are seen as missing
    always @(posedge clock) if (rx_irq === 1'b1) rx_cnt++;
    task automatic test_done();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : test_done
    task automatic bound(input int c, input int lim);
        if (c >= lim) begin
            failures++;
            $display("Error t=%0t wait %h limit %h", $time, c, lim);
            test_done();
        end
    endtask : bound
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clock);
        #1 addr = a;
        wr_data = d;
        wr_en = 1;
        @(posedge clock);
        #1 wr_en = 0;
    endtask : wr
    // Sampled mid-cycle: a read that clears status must not race its own edge
    task automatic rd(input logic [15:0] a, output logic [7:0] d);
        @(posedge clock);
        #1 addr = a;
        rd_en = 1;
        @(negedge clock) d = rd_data;
        @(posedge clock);
        #1 rd_en = 0;
    endtask : rd
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset();
        rd(ADDR_ASYNC_MODE, v);
        `CHK(v, 8'h00)
        rd(ADDR_SYNC_MODE, v);
        `CHK(v, 8'h00)
        rd(ADDR_DATA, v);
        `CHK(v, 8'hff)
        wr(ADDR_DATA, 8'h00);
        rd(ADDR_DATA, v);
        `CHK(v, 8'hff)
        `CHK(tx_line, 1'b1)
        `CHK(pin_port, 1'b0)
        wr(ADDR_SYNC_MODE, 8'hff);
        rd(ADDR_SYNC_MODE, v);
        `CHK(v, 8'h86)
        wr(ADDR_SYNC_MODE, 8'h00);
        wr(ADDR_ASYNC_MODE, 8'h25);
        repeat (2) @(negedge clock);
        `CHK(pin_port, 1'b1)
        $display("t_reset done");
    endtask : t_reset
    // Every parity mode, both lengths, both stop counts
    task automatic t_tx();
        logic [7:0]  d, u;
        logic [11:0] e;
        int          n, c, f0;
        d = 8'hb3;
        for (int i = 0; i < 16; i++) begin
            u = i[2] ? d : {1'b0, d[6:0]};
            e = '1;
            e[0] = 0;
            for (int k = 0; k < 8; k++) if (k < 7 + i[2]) e[1 + k] = u[k];
            n = 8 + i[2];
            if (i[1:0] != 0) begin
                e[n] = (i[1:0] == 2) ? ~^u : (i[1:0] == 3) ? ^u : 1'b0;
                n++;
            end
            n = n + 1 + i[3];
            wr(ADDR_ASYNC_MODE, {2'b10, i[1:0], i[2], i[3], 2'b01});
            f0 = peer.frames;
            wr(ADDR_DATA, d);
            c = 0;
            while (c < 2000 && tx_irq !== 1'b1) begin
                @(posedge clock);
                #1 c++;
            end
            bound(c, 2000);
            `CHK(c >= n * BC - BC / 2 && c <= n * BC + BC / 2, 1'b1)
            c = 0;
            while (c < 1000 && peer.frames == f0) begin
                @(posedge clock);
                c++;
            end
            bound(c, 1000);
            `CHK(peer.frame, e)
        end
        $display("t_tx done");
    endtask : t_tx
    // Good, seven-bit, bad parity masked and unmasked, zero parity unchecked
    task automatic t_rx();
        logic [7:0]  md [5], dt [5], hd [5];
        logic        pb [5], ir [5], er [5];
        logic [11:0] f;
        int          n0, nd;
        md = '{8'h7b, 8'h43, 8'h7b, 8'h79, 8'h5b};
        dt = '{8'h5a, 8'hc5, 8'h5a, 8'h5a, 8'h5a};
        hd = '{8'h5a, 8'h45, 8'h5a, 8'h5a, 8'h5a};
        pb = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b1};
        ir = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b1};
        er = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
        for (int i = 0; i < 5; i++) begin
            wr(ADDR_ASYNC_MODE, md[i]);
            nd = md[i][3] ? 8 : 7;
            f = '1;
            f[0] = 0;
            for (int k = 0; k < nd; k++) f[1 + k] = dt[i][k];
            f[1 + nd] = pb[i];
            n0 = rx_cnt;
            peer.send(f, nd + 3);
            repeat (8) @(posedge clock);
            `CHK(rx_cnt - n0, int'(ir[i]))
            rd(ADDR_ERR_STAT, v);
            `CHK(v[ES_PARITY], er[i])
            rd(ADDR_DATA, v);
            `CHK(v, hd[i])
        end
        wr(ADDR_ASYNC_MODE, 8'h00);
        $display("t_rx done");
    endtask : t_rx
    // LSB then MSB first, each on the external shift clock, then internal
    task automatic t_sync();
        logic [7:0] s;
        logic       p;
        int         c, n;
        for (int j = 0; j < 2; j++) begin
            wr(ADDR_SYNC_MODE, j ? 8'h80 : 8'h84);
            repeat (2) @(negedge clock);
            `CHK(sclk_oe_n, 1'b1)
            // External shift clock: eight rises, six cycles per phase for the pin synchroniser
            wr(ADDR_DATA, 8'h1d);
            for (int k = 0; k < 16; k++) begin
                repeat (6) @(posedge clock);
                if (!k[0]) s = j ? {s[6:0], tx_line} : {tx_line, s[7:1]};
                #1 sclk_in = ~sclk_in;
            end
            `CHK(s, 8'h1d)
            wr(ADDR_SYNC_MODE, j ? 8'h82 : 8'h86);
            repeat (2) @(negedge clock);
            `CHK(sclk_oe_n, 1'b0)
            wr(ADDR_DATA, 8'h1d);
            c = 0;
            n = 0;
            p = 1;
            while (c < 3000 && tx_busy === 1'b1) begin
                @(posedge clock);
                #1 c++;
                if (p === 1'b0 && sclk_out === 1'b1) begin
                    n++;
                    s = j ? {s[6:0], tx_line} : {tx_line, s[7:1]};
                end
                p = sclk_out;
            end
            bound(c, 3000);
            `CHK(n, 8)
            `CHK(s, 8'h1d)
            rd(ADDR_DATA, v);
            `CHK(v, 8'hff)
        end
        wr(ADDR_SYNC_MODE, 8'h00);
        $display("t_sync done");
    endtask : t_sync
    initial begin
        repeat (6) @(posedge clock);
        #1 rst = 0;
        t_reset();
        t_tx();
        t_rx();
        t_sync();
        test_done();
    end
endmodule : dual_mode_serial_channel_test
